// [design/pin_mux_pkg.sv]
// constants for the three-pin function multiplexer of the clock synchronizer
// assumes selector registers are written over the device's own register port
package pin_mux_pkg;
  localparam int PIN_COUNT = 3;
  localparam int SEL_WIDTH = 4;
  localparam int ADDR_WIDTH = 16;
  localparam int DATA_WIDTH = 8;
  localparam int FN_COUNT = 10;

  // selector register addresses
  localparam logic [15:0] PIN0_SEL_ADDR = 16'h0300;
  localparam logic [15:0] PIN1_SEL_ADDR = 16'h0301;
  localparam logic [15:0] PIN2_SEL_ADDR = 16'h0302;
  localparam logic [3:0] SEL_RESET = 4'h0;

  // selector codes
  localparam logic [3:0] CODE_IRQ = 4'h0;
  localparam logic [3:0] CODE_1 = 4'h1;
  localparam logic [3:0] CODE_2 = 4'h2;
  localparam logic [3:0] CODE_3 = 4'h3;
  localparam logic [3:0] CODE_4 = 4'h4;
  localparam logic [3:0] CODE_5 = 4'h5;
  localparam logic [3:0] CODE_6 = 4'h6;
  localparam logic [3:0] CODE_7 = 4'h7;
  localparam logic [3:0] CODE_8 = 4'h8;
  localparam logic [3:0] CODE_GROUP0 = 4'h9;

  // input function indices
  localparam int FN_REF_SELECT = 0;
  localparam int FN_DISABLE0 = 1;
  localparam int FN_DISABLE1 = 2;
  localparam int FN_GROUP0 = 3;
  localparam int FN_GROUP1 = 4;
  localparam int FN_GROUP2 = 5;
  localparam int FN_GROUP3 = 6;
  localparam int FN_GROUP4 = 7;
  localparam int FN_GROUP5 = 8;
  localparam int FN_GROUP6 = 9;
endpackage

// [design/level_synchronizer.sv]
// multi-bit two-flop level synchronizer
// assumes each bit is an independent slow level; no word coherence is given
`timescale 1ns/10ps
module level_synchronizer #(
  parameter int WIDTH = 3,
  parameter int STAGES = 2
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage [STAGES];

  generate
    if (STAGES < 2 || WIDTH < 1) begin : g_bad
      $error("level_synchronizer needs at least two stages");
    end
  endgenerate

  // only the next stage reads the first flop
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < STAGES; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign sync_out = stage[STAGES-1];
endmodule

// [design/pin_function_mux.sv]
// function multiplexer for general-purpose pins 0 to 2
// assumes status inputs are synchronous levels from the pll and monitor logic
//
// Operation
// [R1] code 1010 input: high forces radio outputs 2 and 3 on, else register bit
// [R2] code 1011 input: high forces radio output 4 on, else register bit
// [R3] code 1100 input: high forces radio output 5 on, else register bit
// [R4] code 1101 input: high forces all sync reference outputs on, else global bit
// [R5] code 1110 input: high forces digital outputs 0 and 1 on, else their bits
// [R6] code 1111 input: high forces digital outputs 2 and 3 on, else their bits
// [R7] code 0000 on pins 1 and 2 outputs the pending interrupt level
// [R8] pin 1 code 0001 outputs reference input 1 valid
// [R9] pin 1 codes 0011, 0100, 0101 output second dpll, second apll, rf pll lock
// [R10] pin 1 code 0110 input selects dpll reference 0 or 1
// [R11] pin 1 code 0111 input: high disables reference input 0
// [R12] pin 1 code 1000 input: high disables reference input 1
// [R13] pin 1 codes 1001 to 1111 are group enables, same as pin 0
// [R14] pin 2 code 0001 outputs reference input 0 valid
// [R15] pin 2 codes 0010 and 0011 output first and second dpll holdover
// [R16] pin 2 codes 0100 and 0101 output first and second dpll lock
// [R17] same input function on several pins: lowest pin index wins
// [R18] board logic waits for device ready before using any pin function; the board model drives released pins to the inverse of pin_out before that
// [R19] selectors live at 0x0300-0x0302; a configuration load leaves them alone
// [R20] reserved codes drive low and touch no internal function
// [R21] pin inputs pass two flip-flops before steering anything
`timescale 1ns/10ps
module pin_function_mux
  import pin_mux_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic reg_write,
  input wire logic [pin_mux_pkg::ADDR_WIDTH-1:0] reg_addr,
  input wire logic [pin_mux_pkg::DATA_WIDTH-1:0] reg_wdata,
  output logic [pin_mux_pkg::DATA_WIDTH-1:0] reg_rdata,
  input wire logic config_load,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] pin_in,
  output logic [pin_mux_pkg::PIN_COUNT-1:0] pin_out,
  output logic [pin_mux_pkg::PIN_COUNT-1:0] pin_oe,
  input wire logic interrupt_pending,
  input wire logic ref_input0_valid,
  input wire logic ref_input1_valid,
  input wire logic dpll0_locked,
  input wire logic dpll1_locked,
  input wire logic dpll0_holdover,
  input wire logic dpll1_holdover,
  input wire logic apll0_locked,
  input wire logic apll1_locked,
  input wire logic rf_pll_locked,
  input wire logic ref_select_register,
  input wire logic ref_input0_disable,
  input wire logic ref_input1_disable,
  input wire logic ref_input0_monitor_fail,
  input wire logic ref_input1_monitor_fail,
  input wire logic radio_out01_enable,
  input wire logic radio_out23_enable,
  input wire logic radio_out4_enable,
  input wire logic radio_out5_enable,
  input wire logic sync_ref_outputs_enable,
  input wire logic digital_out0_enable,
  input wire logic digital_out1_enable,
  input wire logic digital_out2_enable,
  input wire logic digital_out3_enable,
  output logic dpll_ref_select,
  output logic ref_input0_disabled,
  output logic ref_input1_disabled,
  output logic radio_out01_on,
  output logic radio_out23_on,
  output logic radio_out4_on,
  output logic radio_out5_on,
  output logic sync_ref_outputs_on,
  output logic digital_out0_on,
  output logic digital_out1_on,
  output logic digital_out2_on,
  output logic digital_out3_on
);
  import pin_mux_pkg::*;

  logic [SEL_WIDTH-1:0] pin0_function_select;
  logic [SEL_WIDTH-1:0] pin1_function_select;
  logic [SEL_WIDTH-1:0] pin2_function_select;
  logic [PIN_COUNT-1:0] pin_sync;
  logic [FN_COUNT-1:0] fn_mask [PIN_COUNT];
  logic [FN_COUNT-1:0] fn_hit;
  logic [FN_COUNT-1:0] fn_level;
  logic [PIN_COUNT-1:0] next_pin_out;
  logic [PIN_COUNT-1:0] next_pin_oe;
  logic [DATA_WIDTH-1:0] next_reg_rdata;

  generate
    if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("pin inputs need at least two synchronizer stages");
    end
  endgenerate

  level_synchronizer #(
    .WIDTH(PIN_COUNT),
    .STAGES(SYNC_STAGES)
  ) u_pin_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(pin_in),
    .sync_out(pin_sync) // [R21]
  );

  // register port decode
  wire sel0_hit = reg_addr == PIN0_SEL_ADDR;
  wire sel1_hit = reg_addr == PIN1_SEL_ADDR;
  wire sel2_hit = reg_addr == PIN2_SEL_ADDR;

  // config_load is deliberately not an input to these flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin0_function_select <= SEL_RESET;
      pin1_function_select <= SEL_RESET;
      pin2_function_select <= SEL_RESET;
    end else if (reg_write) begin
      if (sel0_hit) pin0_function_select <= reg_wdata[SEL_WIDTH-1:0]; // [R19]
      if (sel1_hit) pin1_function_select <= reg_wdata[SEL_WIDTH-1:0]; // [R19]
      if (sel2_hit) pin2_function_select <= reg_wdata[SEL_WIDTH-1:0]; // [R19]
    end
  end

  // unmapped addresses read zero
  assign next_reg_rdata = sel0_hit ? {{(DATA_WIDTH-SEL_WIDTH){1'b0}}, pin0_function_select} :
                          sel1_hit ? {{(DATA_WIDTH-SEL_WIDTH){1'b0}}, pin1_function_select} :
                          sel2_hit ? {{(DATA_WIDTH-SEL_WIDTH){1'b0}}, pin2_function_select} :
                          '0;

  // group enable codes 1001..1111 map straight onto FN_GROUP0..FN_GROUP6
  function automatic logic [FN_COUNT-1:0] group_mask(input logic [SEL_WIDTH-1:0] code);
    logic [FN_COUNT-1:0] m;
    m = '0;
    if (code >= CODE_GROUP0) begin
      m[FN_GROUP0 + int'(code - CODE_GROUP0)] = 1'b1;
    end
    return m;
  endfunction

  // pins 0 and 1 share the input layout; pin 2 has the group codes and the select at 1000
  assign fn_mask[0] = group_mask(pin0_function_select) |
                      (FN_COUNT'(pin0_function_select == CODE_6) << FN_REF_SELECT) |
                      (FN_COUNT'(pin0_function_select == CODE_7) << FN_DISABLE0) |
                      (FN_COUNT'(pin0_function_select == CODE_8) << FN_DISABLE1);
  assign fn_mask[1] = group_mask(pin1_function_select) | // [R13]
                      (FN_COUNT'(pin1_function_select == CODE_6) << FN_REF_SELECT) | // [R10]
                      (FN_COUNT'(pin1_function_select == CODE_7) << FN_DISABLE0) | // [R11]
                      (FN_COUNT'(pin1_function_select == CODE_8) << FN_DISABLE1); // [R12]
  assign fn_mask[2] = group_mask(pin2_function_select) |
                      (FN_COUNT'(pin2_function_select == CODE_8) << FN_REF_SELECT);

  // the lowest pin claiming a function wins, higher pins are ignored
  genvar f;
  generate
    for (f = 0; f < FN_COUNT; f++) begin : g_fn
      assign fn_hit[f] = fn_mask[0][f] | fn_mask[1][f] | fn_mask[2][f];
      assign fn_level[f] = fn_mask[0][f] ? pin_sync[0] : // [R17]
                           fn_mask[1][f] ? pin_sync[1] : // [R17]
                           fn_mask[2][f] & pin_sync[2];
    end
  endgenerate

  wire force_ref_select = fn_hit[FN_REF_SELECT];
  wire next_ref_select = force_ref_select ? fn_level[FN_REF_SELECT] : ref_select_register; // [R10]
  wire next_dis0 = (fn_hit[FN_DISABLE0] & fn_level[FN_DISABLE0]) | ref_input0_disable |
                   ref_input0_monitor_fail; // [R11]
  wire next_dis1 = (fn_hit[FN_DISABLE1] & fn_level[FN_DISABLE1]) | ref_input1_disable |
                   ref_input1_monitor_fail; // [R12]
  wire force_g0 = fn_hit[FN_GROUP0] & fn_level[FN_GROUP0];
  wire force_g1 = fn_hit[FN_GROUP1] & fn_level[FN_GROUP1]; // [R1]
  wire force_g2 = fn_hit[FN_GROUP2] & fn_level[FN_GROUP2]; // [R2]
  wire force_g3 = fn_hit[FN_GROUP3] & fn_level[FN_GROUP3]; // [R3]
  wire force_g4 = fn_hit[FN_GROUP4] & fn_level[FN_GROUP4]; // [R4]
  wire force_g5 = fn_hit[FN_GROUP5] & fn_level[FN_GROUP5]; // [R5]
  wire force_g6 = fn_hit[FN_GROUP6] & fn_level[FN_GROUP6]; // [R6]

  // status outputs; reserved codes fall to the default low
  assign next_pin_out[0] = pin0_function_select == CODE_IRQ ? interrupt_pending :
                           pin0_function_select == CODE_1 ? ref_input0_valid :
                           pin0_function_select == CODE_3 ? dpll1_locked :
                           pin0_function_select == CODE_4 ? apll0_locked :
                           pin0_function_select == CODE_5 ? apll1_locked :
                           1'b0; // [R20]
  assign next_pin_out[1] = pin1_function_select == CODE_IRQ ? interrupt_pending : // [R7]
                           pin1_function_select == CODE_1 ? ref_input1_valid : // [R8]
                           pin1_function_select == CODE_3 ? dpll1_locked : // [R9]
                           pin1_function_select == CODE_4 ? apll1_locked : // [R9]
                           pin1_function_select == CODE_5 ? rf_pll_locked : // [R9]
                           1'b0; // [R20]
  assign next_pin_out[2] = pin2_function_select == CODE_IRQ ? interrupt_pending : // [R7]
                           pin2_function_select == CODE_1 ? ref_input0_valid : // [R14]
                           pin2_function_select == CODE_2 ? dpll0_holdover : // [R15]
                           pin2_function_select == CODE_3 ? dpll1_holdover : // [R15]
                           pin2_function_select == CODE_4 ? dpll0_locked : // [R16]
                           pin2_function_select == CODE_5 ? dpll1_locked : // [R16]
                           pin2_function_select == CODE_6 ? apll0_locked :
                           pin2_function_select == CODE_7 ? rf_pll_locked :
                           1'b0;

  // reserved codes are output type, so the pin is driven low rather than floating
  assign next_pin_oe[0] = pin0_function_select < CODE_6; // [R20]
  assign next_pin_oe[1] = pin1_function_select < CODE_6; // [R7] [R20]
  assign next_pin_oe[2] = pin2_function_select < CODE_8; // [R7]

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= '0;
      pin_oe <= '0;
      reg_rdata <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      reg_rdata <= next_reg_rdata;
    end
  end

  // enables are registered so a pin glitch past the synchronizer lasts a whole cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dpll_ref_select <= 1'b0;
      ref_input0_disabled <= 1'b0;
      ref_input1_disabled <= 1'b0;
      radio_out01_on <= 1'b0;
      radio_out23_on <= 1'b0;
      radio_out4_on <= 1'b0;
      radio_out5_on <= 1'b0;
      sync_ref_outputs_on <= 1'b0;
      digital_out0_on <= 1'b0;
      digital_out1_on <= 1'b0;
      digital_out2_on <= 1'b0;
      digital_out3_on <= 1'b0;
    end else begin
      dpll_ref_select <= next_ref_select; // [R10]
      ref_input0_disabled <= next_dis0; // [R11]
      ref_input1_disabled <= next_dis1; // [R12]
      radio_out01_on <= force_g0 | radio_out01_enable;
      radio_out23_on <= force_g1 | radio_out23_enable; // [R1]
      radio_out4_on <= force_g2 | radio_out4_enable; // [R2]
      radio_out5_on <= force_g3 | radio_out5_enable; // [R3]
      sync_ref_outputs_on <= force_g4 | sync_ref_outputs_enable; // [R4]
      digital_out0_on <= force_g5 | digital_out0_enable; // [R5]
      digital_out1_on <= force_g5 | digital_out1_enable; // [R5]
      digital_out2_on <= force_g6 | digital_out2_enable; // [R6]
      digital_out3_on <= force_g6 | digital_out3_enable; // [R6]
    end
  end
endmodule

// [test/pin_function_mux_asserts.sv]
// port checker for the pin function mux
// assumes selectors change only through the write port
`timescale 1ns/10ps
module pin_mux_checker
  import pin_mux_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic reg_write,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] pin_in,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic interrupt_pending,
  input wire logic ref_input1_valid,
  input wire logic rf_pll_locked,
  input wire logic dpll0_holdover,
  input wire logic ref_input0_disable,
  input wire logic ref_input0_monitor_fail,
  input wire logic ref_input0_disabled,
  input wire logic radio_out23_on
);
  logic [3:0] sel0, sel1, sel2;
  logic live;
  // shadow selectors; a configuration load must not move them
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {sel2, sel1, sel0} <= {3{SEL_RESET}};
      live <= 1'b0;
    end else begin
      live <= 1'b1;
      if (reg_write && reg_addr == PIN0_SEL_ADDR) sel0 <= reg_wdata[3:0];
      if (reg_write && reg_addr == PIN1_SEL_ADDR) sel1 <= reg_wdata[3:0];
      if (reg_write && reg_addr == PIN2_SEL_ADDR) sel2 <= reg_wdata[3:0];
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence s_grp1_high;
    live && sel0 == 4'hA && pin_in[0] ##1 (sel0 == 4'hA) [*2];
  endsequence
  sequence s_claim0;
    live && sel0 == 4'h7 && sel1 == 4'h7;
  endsequence
  property p_irq; live && sel1 == CODE_IRQ |=> pin_out[1] == $past(interrupt_pending) && pin_oe[1]; endproperty
  a_irq: assert property (p_irq) else $error("pin 1 interrupt level wrong");
  property p_ref1; live && sel1 == CODE_1 |=> pin_out[1] == $past(ref_input1_valid); endproperty
  a_ref1: assert property (p_ref1) else $error("pin 1 ref valid wrong");
  property p_rf; live && sel1 == CODE_5 |=> pin_out[1] == $past(rf_pll_locked); endproperty
  a_rf: assert property (p_rf) else $error("pin 1 rf lock wrong");
  property p_hold; live && sel2 == CODE_2 |=> pin_out[2] == $past(dpll0_holdover); endproperty
  a_hold: assert property (p_hold) else $error("pin 2 holdover wrong");
  property p_rsvd; live && sel1 == CODE_2 |=> !pin_out[1] && pin_oe[1]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code not low");
  property p_in_oe; live && sel0 >= CODE_6 |=> !pin_oe[0]; endproperty
  a_in_oe: assert property (p_in_oe) else $error("input pin driven");
  property p_grp1; s_grp1_high |=> radio_out23_on; endproperty
  a_grp1: assert property (p_grp1) else $error("group 1 not forced");
  property p_lowest;
    s_claim0 ##0 !pin_in[0] ##1 s_claim0 ##1 s_claim0 ##0 !ref_input0_disable && !ref_input0_monitor_fail
      |=> !ref_input0_disabled;
  endproperty
  a_lowest: assert property (p_lowest) else $error("higher pin won");
  property p_rback; live && reg_addr == PIN1_SEL_ADDR && !reg_write |=> reg_rdata == {4'h0, $past(sel1)}; endproperty
  a_rback: assert property (p_rback) else $error("selector readback wrong");
endmodule
bind pin_function_mux pin_mux_checker i_checker (.clock, .reset_n, .reg_write, .reg_addr, .reg_wdata, .reg_rdata,
  .pin_in, .pin_out, .pin_oe, .interrupt_pending, .ref_input1_valid, .rf_pll_locked, .dpll0_holdover,
  .ref_input0_disable, .ref_input0_monitor_fail, .ref_input0_disabled, .radio_out23_on);

// [test/board_pin_model.sv]
// board logic on the three pins
// assumes the bench raises device_ready once startup is over
`timescale 1ns/10ps
module board_pin_model (
  input wire logic device_ready,
  input wire logic [2:0] drive_value,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  output logic [2:0] pin_level
);
  // the board drives drive_value on a released pin once the device is ready; before that it drives the inverse of pin_out
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : (device_ready ? drive_value[i] : ~pin_out[i]);
    end
  end
endmodule

// [test/pin_function_mux_tb_top.sv]
// bench for the pin function mux with the board model on the pins
// assumes a 100 MHz clock and the codes of pin_mux_pkg
`timescale 1ns/10ps
module pin_function_mux_tb_top;
  import pin_mux_pkg::*;
  logic clock = 1'b0, reset_n = 1'b0, reg_write = 1'b0, config_load = 1'b0, rsel = 1'b0, ready = 1'b0;
  logic [15:0] reg_addr = 16'h0;
  logic [7:0] reg_wdata = 8'h0;
  logic [9:0] st = 10'h0;
  logic [8:0] en = 9'h0;
  logic [1:0] dis = 2'h0;
  logic [1:0] mon = 2'h0;
  logic [2:0] drv = 3'h0;
  logic [7:0] rdata;
  logic [2:0] pin_in, pin_out, pin_oe;
  logic sel_out, dis0, dis1;
  logic [8:0] on;
  int num_errors = 0, n_checks = 0, cycles = 0;
  always #5 clock = ~clock;
  board_pin_model i_board (.device_ready(ready), .drive_value(drv), .pin_out, .pin_oe, .pin_level(pin_in));
  pin_function_mux i_dut (.clock, .reset_n, .reg_write, .reg_addr, .reg_wdata, .reg_rdata(rdata), .config_load,
    .pin_in, .pin_out, .pin_oe, .interrupt_pending(st[0]), .ref_input0_valid(st[1]), .ref_input1_valid(st[2]),
    .dpll0_locked(st[3]), .dpll1_locked(st[4]), .dpll0_holdover(st[5]), .dpll1_holdover(st[6]),
    .apll0_locked(st[7]), .apll1_locked(st[8]), .rf_pll_locked(st[9]), .ref_select_register(rsel),
    .ref_input0_disable(dis[0]), .ref_input1_disable(dis[1]), .ref_input0_monitor_fail(mon[0]),
    .ref_input1_monitor_fail(mon[1]), .radio_out01_enable(en[0]), .radio_out23_enable(en[1]),
    .radio_out4_enable(en[2]), .radio_out5_enable(en[3]), .sync_ref_outputs_enable(en[4]),
    .digital_out0_enable(en[5]), .digital_out1_enable(en[6]), .digital_out2_enable(en[7]),
    .digital_out3_enable(en[8]), .dpll_ref_select(sel_out), .ref_input0_disabled(dis0),
    .ref_input1_disabled(dis1), .radio_out01_on(on[0]), .radio_out23_on(on[1]), .radio_out4_on(on[2]),
    .radio_out5_on(on[3]), .sync_ref_outputs_on(on[4]), .digital_out0_on(on[5]), .digital_out1_on(on[6]),
    .digital_out2_on(on[7]), .digital_out3_on(on[8]));
  task automatic summarize();
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // checks run at an edge and see the settled values from before it
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    cyc(3);
    chk(9'(rdata), 9'(exp));
  endtask
  task automatic t_regs();
    cyc(2);
    chk(9'(pin_oe), 9'h007);
    rd(PIN0_SEL_ADDR, 8'h00);
    wr(16'h0304, 8'h05);
    rd(16'h0304, 8'h00);
    wr(PIN1_SEL_ADDR, 8'hFB);
    wr(PIN2_SEL_ADDR, 8'h0C);
    @(posedge clock);
    config_load <= 1'b1;
    @(posedge clock);
    config_load <= 1'b0;
    rd(PIN1_SEL_ADDR, 8'h0B);
    rd(PIN2_SEL_ADDR, 8'h0C);
  endtask
  // six codes on pin 1, eight on pin 2, six on pin 0; status index 10 marks the reserved code
  task automatic t_status();
    logic [79:0] codes = 80'h25431076543210254310;
    logic [79:0] idx = 80'hA8741097436510A98420;
    int p;
    for (int i = 0; i < 20; i++) begin
      p = i < 6 ? 1 : (i < 14 ? 2 : 0);
      wr(i < 6 ? PIN1_SEL_ADDR : (i < 14 ? PIN2_SEL_ADDR : PIN0_SEL_ADDR), {4'h0, codes[4*i +: 4]});
      for (int v = 0; v < 2; v++) begin
        st <= v == 1 ? 10'h1 << idx[4*i +: 4] : ~(10'h1 << idx[4*i +: 4]);
        cyc(3);
        chk(9'({pin_oe[p], pin_out[p]}), 9'({1'b1, v == 1 && idx[4*i +: 4] != 4'hA}));
      end
    end
  endtask
  task automatic t_groups();
    logic [8:0] m;
    for (int p = 0; p < 3; p++) begin
      for (int c = 9; c < 16; c++) begin
        m = c < 14 ? 9'h001 << (c - 9) : (c == 14 ? 9'h060 : 9'h180);
        wr(16'(PIN0_SEL_ADDR + p), 8'(c));
        drv <= 3'(1 << p);
        cyc(5);
        chk(on, m);
        drv <= 3'h0;
        en <= m;
        cyc(5);
        chk(on, m);
        en <= 9'h000;
        cyc(5);
        chk(on, 9'h000);
      end
      wr(16'(PIN0_SEL_ADDR + p), 8'h00);
    end
  endtask
  task automatic t_ref();
    wr(PIN1_SEL_ADDR, 8'h06);
    rsel <= 1'b1;
    drv <= 3'h2;
    cyc(5);
    chk(9'(sel_out), 9'h001);
    drv <= 3'h0;
    cyc(5);
    chk(9'(sel_out), 9'h000);
    for (int c = 7; c < 9; c++) begin
      wr(PIN1_SEL_ADDR, 8'(c));
      drv <= 3'h2;
      cyc(5);
      chk(9'({dis1, dis0}), 9'(c - 6));
      chk(9'(sel_out), 9'h001);
      drv <= 3'h0;
      dis <= 2'h3;
      cyc(5);
      chk(9'({dis1, dis0}), 9'h003);
      dis <= 2'h0;
      cyc(5);
      chk(9'({dis1, dis0}), 9'h000);
      mon <= 2'h3;
      cyc(5);
      chk(9'({dis1, dis0}), 9'h003);
      mon <= 2'h0;
    end
    wr(PIN1_SEL_ADDR, 8'h07);
    wr(PIN0_SEL_ADDR, 8'h07);
    drv <= 3'h2;
    cyc(5);
    chk(9'(dis0), 9'h000);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    cyc(3);
    reset_n <= 1'b1;
    t_regs();
    ready <= 1'b1;
    t_status();
    t_groups();
    t_ref();
    summarize();
  end
endmodule
